// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic mclk_i = 1'b0, reset_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0, block0 = 1'b0;
  logic hreadyout_o, hresp_o;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, lfsr = 32'd35;
  logic [31:0] hrdata_o, event_stamp_o, rd, c;
  logic [1:0] htrans_i = 2'h0;
  logic [2:0] blk_bg = 3'h0;
  logic [2:0][15:0] ratio_bg = '0;
  logic [15:0] ratio0 = 16'h1000, meas = 16'h0;
  logic [15:0] event_voltage_o;
  logic [3:0] start_o, trip_o, blocked_o;
  logic [3:0][19:0] remaining_o;
  logic [23:0] event_o;
  int fails = 0, checks_done = 0, n;
  localparam logic [7:0] ADR [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h44, 8'h60};
  localparam logic [31:0] DFL [6] = '{32'h69, 32'd8, 32'd12, 32'h00640005, 32'h00ffffff, 32'h0};
  localparam logic [2:0] GRP = 3'h5;
  vstt_voltage_stage_trip_timer #(.TICK_CYCLES(10), .MS_CYCLES(4)) uut (.mclk_i(mclk_i), .reset_i(reset_i),
    .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .ratio_i({ratio_bg, ratio0}), .block_i({blk_bg, block0}), .measured_voltage_i(meas),
    .setting_group_i(GRP), .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o),
    .remaining_o(remaining_o), .event_o(event_o), .event_stamp_o(event_stamp_o),
    .event_voltage_o(event_voltage_o));
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Tick-level view of the operate and release counters, times in clock cycles
  function automatic void model(input logic [31:0] cf, input int dly, rel, input logic [9:0] pat,
                                output int tt, output int tf);
    int cnt;
    int rc;
    logic tr;
    tt = -1;
    tf = -1;
    cnt = 0;
    rc = 0;
    tr = 1'b0;
    for (int j = 0; j < 9; j++) begin
      if (j == 0 || pat[j]) begin
        rc = 0;
        cnt++;
        if (!tr && cnt >= dly) begin
          tr = 1'b1;
          tt = 10 * j;
        end
      end else if (tr) begin
        tf = 10 * j;
        break;
      end else begin
        rc++;
        if (cf[5:4] == vstt_pkg::SEL_NO) cnt = 0;
        else if (cf[7:6] == vstt_pkg::SEL_YES) cnt++;
        if (cf[3:2] == vstt_pkg::SEL_NO || rc >= rel) begin
          tf = 10 * j;
          break;
        end
      end
    end
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    n = 0;
    @(posedge mclk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    haddr_i <= {24'h0, a};
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1 && ++n < 50);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1 && ++n < 50);
    rd = hrdata_o;
    if (n >= 50) fails++;
  endtask
  task automatic run(input logic [31:0] cf, input int dly, rel, input logic [9:0] pat, input logic ev);
    int t_trip;
    int t_fall;
    int et;
    int ef;
    int k;
    logic [15:0] hi;
    logic [15:0] lo;
    logic [15:0] hv;
    hi = cf[8] ? 16'h0fff : 16'h1001;
    lo = cf[8] ? 16'd4219 : 16'd3973;
    bus(1'b1, 8'h00, cf);
    bus(1'b1, 8'h04, 32'(dly));
    bus(1'b1, 8'h08, 32'(rel));
    ratio0 <= hi;
    k = 0;
    do begin
      hv = meas;
      @(posedge mclk_i);
    end while (start_o[0] !== 1'b1 && ++k < 100);
    check(32'(event_o[0]), 32'(ev));
    check(32'(event_voltage_o), 32'(hv));
    t_trip = -1;
    t_fall = -1;
    for (k = 0; k < 90; k++) begin
      if (t_fall < 0 && t_trip < 0 && trip_o[0] === 1'b1) t_trip = k;
      if (t_fall < 0 && start_o[0] !== 1'b1) t_fall = k;
      if (k == 5) check(32'(remaining_o[0]), 32'(dly > 0 ? dly - 1 : 0));
      if (k % 10 == 5) ratio0 <= pat[k / 10 + 1] ? hi : lo;
      @(posedge mclk_i);
    end
    // At or past the reset level (at it for over, above it for under): at 1.00 hysteresis would hold the pickup
    ratio0 <= lo;
    model(cf, dly, rel, pat, et, ef);
    check(32'(t_trip), 32'(et));
    check(32'(t_fall), 32'(ef));
    k = 0;
    do @(posedge mclk_i); while ((start_o[0] | trip_o[0]) !== 1'b0 && ++k < 300);
    if (k >= 300) fails++;
    ratio0 <= vstt_pkg::RATIO_ONE;
    // Counter may still sit in release after start has dropped
    repeat (60) @(posedge mclk_i);
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (60000) @(posedge mclk_i);
    fails++;
    give_verdict();
  end
  always @(posedge mclk_i) begin
    lfsr <= lfsr_next(lfsr);
    if (lfsr[3:0] == 4'h0) begin
      ratio_bg <= {lfsr[31:16], lfsr[15:0], lfsr[27:12]};
      blk_bg <= lfsr[6:4];
      meas <= lfsr[23:8];
    end
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, ADR[i], 32'h0);
      check(rd, DFL[i]);
    end
    run(32'h69, 8, 12, 10'h3ff, 1'b1);
    bus(1'b0, 8'h40, 32'h0);
    check(32'({rd[19:16], rd[8], rd[4], rd[0]}), 32'h10);
    bus(1'b1, 8'h4c, 32'h301);
    bus(1'b0, 8'h50, 32'h0);
    check(32'(rd[5:0]), 32'({GRP, vstt_pkg::REC_TRIP}));
    run(32'h69, 0, 12, 10'h3ff, 1'b1);
    run(32'h69, 4, 3, 10'h3fb, 1'b1);
    run(32'h59, 4, 3, 10'h3fb, 1'b1);
    run(32'ha9, 4, 3, 10'h3fb, 1'b1);
    run(32'ha9, 3, 3, 10'h003, 1'b1);
    run(32'h69, 8, 5, 10'h001, 1'b1);
    run(32'h65, 8, 5, 10'h001, 1'b1);
    bus(1'b1, 8'h44, 32'h00fffffe);
    run(32'h69, 0, 12, 10'h3ff, 1'b0);
    bus(1'b1, 8'h44, 32'h00ffffff);
    for (int i = 0; i < 4; i++) begin
      c = {23'h0, lfsr[8], 2'b01, lfsr[9], ~lfsr[9], lfsr[10], ~lfsr[10], 2'b01};
      run(c, int'(lfsr[18:16]) % 7, int'(lfsr[20:19]), lfsr[30:21], 1'b1);
    end
    // Ratio 2.00, a 1.00, k 0.05 s: operate time is ten ticks
    bus(1'b1, 8'h00, 32'h6a);
    bus(1'b1, 8'h0c, 32'h00640005);
    ratio0 <= 16'h2000;
    n = 0;
    do @(posedge mclk_i); while (start_o[0] !== 1'b1 && ++n < 100);
    rd = event_stamp_o;
    repeat (99) @(posedge mclk_i);
    check(32'({trip_o[0], remaining_o[0]}), 32'h0);
    @(posedge mclk_i);
    check(32'(trip_o[0]), 32'h1);
    check(event_stamp_o - rd, 32'(100 / 4));
    ratio0 <= 16'd3973;
    repeat (30) @(posedge mclk_i);
    bus(1'b1, 8'h00, 32'h65);
    // Block well ahead of any operate delay
    block0 <= 1'b1;
    ratio0 <= 16'h1001;
    n = 0;
    do @(posedge mclk_i); while (blocked_o[0] !== 1'b1 && ++n < 100);
    check(32'({start_o[0], event_o[4]}), 32'h1);
    block0 <= 1'b0;
    n = 0;
    do @(posedge mclk_i); while (start_o[0] !== 1'b1 && ++n < 100);
    block0 <= 1'b1;
    n = 0;
    do @(posedge mclk_i); while (blocked_o[0] !== 1'b1 && ++n < 100);
    check(32'({start_o[0], event_o[1], event_o[4]}), 32'h3);
    block0 <= 1'b0;
    ratio0 <= vstt_pkg::RATIO_ONE;
    repeat (30) @(posedge mclk_i);
    give_verdict();
  end
endmodule // testbench

// >>> verif/vstt_trip_timer_monitor.sv
`timescale 1ns/1ps
module vstt_trip_timer_monitor (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [3:0] start_o,
  input wire logic [3:0] trip_o,
  input wire logic [3:0] blocked_o,
  input wire logic [23:0] event_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  chk_resp_okay: assert property (hresp_o == 1'b0)
    else $error("bus response not okay");
  chk_read_wait: assert property (hsel_i && htrans_i[1] && hready_i && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");
  // Start and trip move only after a tick, so neither may change for the next eight cycles
  chk_start_steady: assert property ($changed(start_o) |=> $stable(start_o) [*8])
    else $error("start moved between ticks");
  chk_trip_steady: assert property ($changed(trip_o) |=> $stable(trip_o) [*8])
    else $error("trip moved between ticks");
  chk_event_pulse: assert property ((|event_o) |=> (event_o == 24'h0))
    else $error("event longer than one cycle");
  chk_start_event: assert property (event_o[0] |-> $rose(start_o[0]))
    else $error("start on event without start edge");
  chk_trip_event: assert property (event_o[2] |-> $rose(trip_o[0]))
    else $error("trip on event without trip edge");
  chk_block_off: assert property (event_o[5] |-> $fell(blocked_o[0]))
    else $error("block off event without blocked fall");
  chk_trip_start: assert property ($rose(trip_o[0]) |-> start_o[0])
    else $error("trip raised without start");
  cov_instant: cover property ($rose(start_o[0]) && $rose(trip_o[0]));
  cov_blocked: cover property ($rose(blocked_o[0]));
  cov_release: cover property ($fell(start_o[0]) && !trip_o[0]);
endmodule // vstt_trip_timer_monitor

bind vstt_voltage_stage_trip_timer vstt_trip_timer_monitor u_monitor (.mclk_i(mclk_i), .reset_i(reset_i),
  .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o), .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o), .event_o(event_o));

// >>> verilog/vstt_pkg.sv
package vstt_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_TIME_NS = 5000000;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int MS_TIME_NS = 1000000;
  localparam int MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;
  localparam int TICK_MS = 5;
  localparam int OP_DEFAULT_MS = 40;
  localparam int REL_DEFAULT_MS = 60;
  localparam int PRE_TRIG_MS = 20;
  localparam int PRE_FAULT_MS = 200;
  localparam int PRE_TRIG_TICKS = PRE_TRIG_MS / TICK_MS;
  localparam int HIST_DEPTH = PRE_FAULT_MS / TICK_MS;
  localparam int NUM_STAGES = 4;
  localparam int REC_DEPTH = 12;
  localparam int EV_PER_STAGE = 6;
  localparam int NUM_EVENTS = NUM_STAGES * EV_PER_STAGE;
  localparam logic [1:0] SEL_DT = 2'h1;
  localparam logic [1:0] SEL_INVERSE_TIME_MODE = 2'h2;
  localparam logic [1:0] SEL_NO = 2'h1;
  localparam logic [1:0] SEL_YES = 2'h2;
  localparam logic [12:0] K_DEFAULT = 13'h0005;
  localparam logic [11:0] A_DEFAULT = 12'h064;
  localparam int RATIO_FRAC = 12;
  localparam int RATIO_ONE_INT = 4096;
  localparam logic [15:0] RATIO_ONE = 16'h1000;
  localparam logic [15:0] DROP_OVER = 16'((RATIO_ONE_INT * 97) / 100);
  localparam logic [15:0] DROP_UNDER = 16'((RATIO_ONE_INT * 103) / 100);
  localparam int K_SHIFT = 13;
  localparam logic [7:0] STAGE_END = 8'h40;
  localparam int STAGE_SEL_LSB = 4;
  localparam logic [3:0] OFS_CFG = 4'h0;
  localparam logic [3:0] OFS_DELAY = 4'h4;
  localparam logic [3:0] OFS_RELEASE = 4'h8;
  localparam logic [3:0] OFS_INVERSE_TIME_MODE = 4'hc;
  localparam logic [7:0] ADDR_STATUS = 8'h40;
  localparam logic [7:0] ADDR_EVMASK = 8'h44;
  localparam logic [7:0] ADDR_TIME = 8'h48;
  localparam logic [7:0] ADDR_RECSEL = 8'h4c;
  localparam logic [7:0] ADDR_RECDATA = 8'h50;
  localparam int CFG_TYPE_LSB = 0;
  localparam int CFG_DELREL_LSB = 2;
  localparam int CFG_RSTAFT_LSB = 4;
  localparam int CFG_CONT_LSB = 6;
  localparam int CFG_UNDER_BIT = 8;
  localparam int INVERSE_TIME_MODE_K_LSB = 0;
  localparam int INVERSE_TIME_MODE_A_LSB = 16;
  localparam int RECSEL_STAGE_LSB = 4;
  localparam int RECSEL_WORD_LSB = 8;
  localparam int ST_TRIP_LSB = 4;
  localparam int ST_BLK_LSB = 8;
  localparam int ST_PTR_LSB = 16;
  localparam logic [23:0] EVMASK_RESET = 24'hffffff;
  localparam logic [2:0] REC_START = 3'h1;
  localparam logic [2:0] REC_TRIP = 3'h2;
  localparam logic [2:0] REC_BLOCK = 3'h3;
  typedef enum logic [1:0] {PH_IDLE, PH_OPERATE, PH_TRIPPED, PH_RELEASE} vstt_phase_type;
  typedef struct packed {
    logic [1:0] delay_type;
    logic [1:0] delayed_release;
    logic [1:0] reset_after;
    logic [1:0] continue_release;
    logic under;
    logic [18:0] op_delay;
    logic [14:0] release_delay;
    logic [12:0] dial_k;
    logic [11:0] exponent_a;
  } vstt_cfg_type;
  localparam vstt_cfg_type CFG_RESET = '{SEL_DT, SEL_YES, SEL_YES, SEL_NO, 1'b0,
    19'(OP_DEFAULT_MS / TICK_MS), 15'(REL_DEFAULT_MS / TICK_MS), K_DEFAULT, A_DEFAULT};
  typedef struct packed {
    logic [31:0] stamp;
    logic [15:0] pre_trigger;
    logic [15:0] fault;
    logic [15:0] pre_fault;
    logic [19:0] remaining;
    logic [2:0] group;
    logic [2:0] event_code;
  } vstt_record_type;
endpackage

// >>> verilog/vstt_voltage_stage_trip_timer.sv
`timescale 1ns/1ps
// Function
// - Instant mode raises trip on the same tick as start.
// - Fixed delay mode trips after set delay while pickup stays active.
// - Inverse time: k over (ratio^a minus one), or one minus ratio^a.
// - Delay type code 1 fixed, 2 inverse; fixed by default.
// - Fixed delay in 5 ms steps, default 40 ms, used only in fixed mode.
// - Fixed delay of zero or one tick behaves as instant, longer as delayed.
// - Dial k in 0.01 s steps, used only in inverse mode.
// - Exponent a in 0.01 steps, default 1.00, powers the ratio.
// - Release delay in 5 ms steps, default 60 ms, holds start.
// - Delayed release 1 no, 2 yes; yes drops start after release delay.
// - Reset-after-release yes clears counter after release, no at once.
// - Continue-during-release yes keeps counting if reset-after is yes, default no freezes.
// - Counting during release never trips without renewed pickup.
// - Default: 60 ms release, operate count held during release.
// - Events on every change, per-event mask for on and off.
// - Four stages, each with six events.
// - Each event carries time stamp and voltage.
// - Twelve newest on-event records per stage, oldest overwritten.
// - Record holds time, event, voltages, remaining time, group.
// - Block sampled each tick; blocks start and releases active start.
// - Pickup drops at 97 percent over, 103 percent under.
module vstt_voltage_stage_trip_timer #(
  parameter int TICK_CYCLES = vstt_pkg::TICK_CYCLES,
  parameter int MS_CYCLES = vstt_pkg::MS_CYCLES
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [3:0][15:0] ratio_i,
  input wire logic [3:0] block_i,
  input wire logic [15:0] measured_voltage_i,
  input wire logic [2:0] setting_group_i,
  output logic [3:0] start_o,
  output logic [3:0] trip_o,
  output logic [3:0] blocked_o,
  output logic [3:0][19:0] remaining_o,
  output logic [23:0] event_o,
  output logic [31:0] event_stamp_o,
  output logic [15:0] event_voltage_o
);
  localparam int NS = vstt_pkg::NUM_STAGES;
  localparam int NE = vstt_pkg::NUM_EVENTS;
  localparam int HD = vstt_pkg::HIST_DEPTH;

  // Log2/exp2 by leading-one split; a few percent error, no divider needed
  function automatic logic [31:0] vstt_power(input logic [15:0] r, input logic [11:0] a);
    int p;
    logic [15:0] m;
    logic signed [17:0] lg;
    logic signed [41:0] pr;
    logic signed [29:0] n;
    logic [12:0] base;
    logic [31:0] y;
    p = -1;
    y = 32'h0;
    for (int i = 0; i < 16; i++) begin
      if (r[i]) begin
        p = i;
      end
    end
    if (p >= 0) begin
      m = r << (15 - p);
      lg = 18'(signed'(p - vstt_pkg::RATIO_FRAC)) * 18'sh01000 + 18'(m[14:3]);
      pr = (42'(lg) * 42'(signed'({1'b0, a})) * 42'sd655) >>> 16;
      n = 30'(pr >>> vstt_pkg::RATIO_FRAC);
      base = {1'b1, pr[11:0]};
      if (n > 30'sd18) begin
        y = 32'hffffffff;
      end else if (n >= 30'sd0) begin
        y = 32'(base) << n;
      end else if (n > -30'sd14) begin
        y = 32'(base) >> (-n);
      end
    end
    return y;
  endfunction

  vstt_pkg::vstt_cfg_type cfg [NS];
  vstt_pkg::vstt_cfg_type next_cfg [NS];
  vstt_pkg::vstt_record_type rec_mem [NS][vstt_pkg::REC_DEPTH];
  vstt_pkg::vstt_record_type rec_d [NS];
  logic rec_we [NS];
  logic [3:0] wp [NS];
  logic st_q [NS];
  logic st_d [NS];
  logic tr_q [NS];
  logic tr_d [NS];
  logic bl_q [NS];
  logic bl_d [NS];
  logic [19:0] rem [NS];
  logic [15:0] hist [HD];
  logic [15:0] next_hist [HD];
  logic [31:0] tick_cnt, next_tick_cnt, ms_cnt, next_ms_cnt, stamp, next_stamp;
  logic tick, next_tick;
  logic [23:0] evmask, next_evmask, next_event;
  logic [9:0] recsel, next_recsel;
  logic wr_pend, next_wr_pend, rd_pend, next_rd_pend, next_hreadyout;
  logic [7:0] wr_addr, next_wr_addr, rd_addr, next_rd_addr;
  logic [31:0] next_hrdata, rdv;
  logic [3:0][19:0] next_rem;
  logic take;
  vstt_pkg::vstt_record_type rsel;

  // Program-cycle tick and millisecond time base
  always_comb begin
    next_tick = 1'b0;
    next_tick_cnt = tick_cnt + 32'h1;
    if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      next_tick_cnt = 32'h0;
      next_tick = 1'b1;
    end
    next_ms_cnt = ms_cnt + 32'h1;
    next_stamp = stamp;
    if (ms_cnt >= 32'(MS_CYCLES - 1)) begin
      next_ms_cnt = 32'h0;
      next_stamp = stamp + 32'h1;
    end
    if (wr_pend && wr_addr == vstt_pkg::ADDR_TIME) begin
      next_stamp = hwdata_i;
    end
    next_hist = hist;
    if (tick) begin
      next_hist[0] = measured_voltage_i;
      for (int i = 1; i < HD; i++) begin
        next_hist[i] = hist[i - 1];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      tick_cnt <= 32'h0;
      tick <= 1'b0;
      ms_cnt <= 32'h0;
      stamp <= 32'h0;
      for (int i = 0; i < HD; i++) begin
        hist[i] <= 16'h0;
      end
    end else begin
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
      ms_cnt <= next_ms_cnt;
      stamp <= next_stamp;
      hist <= next_hist;
    end
  end

  for (genvar s = 0; s < NS; s++) begin : g_stage
    vstt_pkg::vstt_phase_type ph, next_ph;
    logic pick, next_pick, eff, inverse_time_mode;
    logic [31:0] cnt, next_cnt, inc, lim, pw, dev;
    logic [32:0] sum;
    logic [14:0] relc, next_relc, rc;
    logic [15:0] pf, next_pf;
    logic [3:0] next_wp;

    assign inverse_time_mode = cfg[s].delay_type == vstt_pkg::SEL_INVERSE_TIME_MODE;
    assign pw = vstt_power(ratio_i[s], cfg[s].exponent_a);

    always_comb begin
      // Over: ratio^a - 1; under: 1 - ratio^a, clipped at zero
      dev = 32'h0;
      if (!cfg[s].under && pw > 32'(vstt_pkg::RATIO_ONE)) begin
        dev = pw - 32'(vstt_pkg::RATIO_ONE);
      end else if (cfg[s].under && pw < 32'(vstt_pkg::RATIO_ONE)) begin
        dev = 32'(vstt_pkg::RATIO_ONE) - pw;
      end
      // Accumulating dev per tick until k*200 gives t = k/dev
      inc = inverse_time_mode ? dev : 32'h1;
      lim = inverse_time_mode ? (32'(cfg[s].dial_k) << vstt_pkg::K_SHIFT) : 32'(cfg[s].op_delay);
      sum = {1'b0, cnt} + {1'b0, inc};
      rc = (ph == vstt_pkg::PH_RELEASE) ? relc + 15'h1 : 15'h1;
      next_pick = pick;
      if (cfg[s].under) begin
        next_pick = pick ? (ratio_i[s] <= vstt_pkg::DROP_UNDER) : (ratio_i[s] < vstt_pkg::RATIO_ONE);
      end else begin
        next_pick = pick ? (ratio_i[s] > vstt_pkg::DROP_OVER) : (ratio_i[s] > vstt_pkg::RATIO_ONE);
      end
      eff = next_pick && !block_i[s];
      next_ph = ph;
      next_cnt = cnt;
      next_relc = relc;
      next_pf = pf;
      st_d[s] = st_q[s];
      tr_d[s] = tr_q[s];
      bl_d[s] = bl_q[s];
      if (!tick) begin
        next_pick = pick;
      end else begin
        bl_d[s] = next_pick && block_i[s];
        if (eff && ph != vstt_pkg::PH_TRIPPED) begin
          st_d[s] = 1'b1;
          next_relc = 15'h0;
          next_cnt = sum[32] ? 32'hffffffff : sum[31:0];
          next_ph = vstt_pkg::PH_OPERATE;
          // Zero delay meets the limit at once: instant trip
          if (sum >= {1'b0, lim}) begin
            tr_d[s] = 1'b1;
            next_ph = vstt_pkg::PH_TRIPPED;
          end
        end else if (!eff && ph == vstt_pkg::PH_TRIPPED) begin
          st_d[s] = 1'b0;
          tr_d[s] = 1'b0;
          next_cnt = 32'h0;
          next_ph = vstt_pkg::PH_IDLE;
        end else if (!eff && ph != vstt_pkg::PH_IDLE) begin
          if (rc >= cfg[s].release_delay) begin
            st_d[s] = 1'b0;
            next_cnt = 32'h0;
            next_relc = 15'h0;
            next_ph = vstt_pkg::PH_IDLE;
          end else begin
            next_relc = rc;
            next_ph = vstt_pkg::PH_RELEASE;
            st_d[s] = cfg[s].delayed_release == vstt_pkg::SEL_YES;
            if (cfg[s].reset_after != vstt_pkg::SEL_YES) begin
              next_cnt = 32'h0;
            end else if (cfg[s].continue_release == vstt_pkg::SEL_YES) begin
              next_cnt = sum[32] ? 32'hffffffff : sum[31:0];
            end
          end
        end
        if (st_d[s] && !st_q[s]) begin
          next_pf = hist[HD - 1];
        end
      end
      next_rem[s] = (inverse_time_mode || cnt >= lim) ? 20'h0 : 20'(lim - cnt);
      // One record per tick; trip outranks start outranks block
      rec_we[s] = (st_d[s] && !st_q[s]) || (tr_d[s] && !tr_q[s]) || (bl_d[s] && !bl_q[s]);
      rec_d[s].stamp = stamp;
      rec_d[s].pre_trigger = hist[vstt_pkg::PRE_TRIG_TICKS - 1];
      rec_d[s].fault = measured_voltage_i;
      rec_d[s].pre_fault = next_pf;
      rec_d[s].remaining = next_rem[s];
      rec_d[s].group = setting_group_i;
      rec_d[s].event_code = (tr_d[s] && !tr_q[s]) ? vstt_pkg::REC_TRIP :
        (st_d[s] && !st_q[s]) ? vstt_pkg::REC_START : vstt_pkg::REC_BLOCK;
      next_wp = wp[s];
      if (rec_we[s]) begin
        next_wp = (wp[s] == 4'(vstt_pkg::REC_DEPTH - 1)) ? 4'h0 : wp[s] + 4'h1;
      end
    end

    always_ff @(posedge mclk_i) begin
      if (reset_i) begin
        ph <= vstt_pkg::PH_IDLE;
        pick <= 1'b0;
        cnt <= 32'h0;
        relc <= 15'h0;
        pf <= 16'h0;
        wp[s] <= 4'h0;
        st_q[s] <= 1'b0;
        tr_q[s] <= 1'b0;
        bl_q[s] <= 1'b0;
        rem[s] <= 20'h0;
      end else begin
        ph <= next_ph;
        pick <= next_pick;
        cnt <= next_cnt;
        relc <= next_relc;
        pf <= next_pf;
        wp[s] <= next_wp;
        st_q[s] <= st_d[s];
        tr_q[s] <= tr_d[s];
        bl_q[s] <= bl_d[s];
        rem[s] <= next_rem[s];
      end
    end

    assign start_o[s] = st_q[s];
    assign trip_o[s] = tr_q[s];
    assign blocked_o[s] = bl_q[s];
    assign remaining_o[s] = rem[s];
  end

  // Events for each stage, filtered by the on/off mask
  always_comb begin
    for (int s = 0; s < NS; s++) begin
      next_event[s * 6 + 0] = st_d[s] && !st_q[s];
      next_event[s * 6 + 1] = !st_d[s] && st_q[s];
      next_event[s * 6 + 2] = tr_d[s] && !tr_q[s];
      next_event[s * 6 + 3] = !tr_d[s] && tr_q[s];
      next_event[s * 6 + 4] = bl_d[s] && !bl_q[s];
      next_event[s * 6 + 5] = !bl_d[s] && bl_q[s];
    end
    next_event = next_event & evmask;
  end

  // Record store; memory kept in one process to avoid split drivers
  always_ff @(posedge mclk_i) begin
    for (int s = 0; s < NS; s++) begin
      if (rec_we[s]) begin
        rec_mem[s][wp[s]] <= rec_d[s];
      end
    end
  end

  // Reads take one wait state so a write just before is visible
  assign take = hsel_i && htrans_i[1] && hready_i;
  assign rsel = rec_mem[recsel[vstt_pkg::RECSEL_STAGE_LSB +: 2]][recsel[3:0] % 4'(vstt_pkg::REC_DEPTH)];

  always_comb begin
    rdv = 32'h0;
    if (rd_addr < vstt_pkg::STAGE_END) begin
      case (rd_addr[3:0])
        vstt_pkg::OFS_CFG: begin
          rdv[vstt_pkg::CFG_TYPE_LSB +: 2] = cfg[rd_addr[5:4]].delay_type;
          rdv[vstt_pkg::CFG_DELREL_LSB +: 2] = cfg[rd_addr[5:4]].delayed_release;
          rdv[vstt_pkg::CFG_RSTAFT_LSB +: 2] = cfg[rd_addr[5:4]].reset_after;
          rdv[vstt_pkg::CFG_CONT_LSB +: 2] = cfg[rd_addr[5:4]].continue_release;
          rdv[vstt_pkg::CFG_UNDER_BIT] = cfg[rd_addr[5:4]].under;
        end
        vstt_pkg::OFS_DELAY: rdv[18:0] = cfg[rd_addr[5:4]].op_delay;
        vstt_pkg::OFS_RELEASE: rdv[14:0] = cfg[rd_addr[5:4]].release_delay;
        vstt_pkg::OFS_INVERSE_TIME_MODE: begin
          rdv[vstt_pkg::INVERSE_TIME_MODE_K_LSB +: 13] = cfg[rd_addr[5:4]].dial_k;
          rdv[vstt_pkg::INVERSE_TIME_MODE_A_LSB +: 12] = cfg[rd_addr[5:4]].exponent_a;
        end
        default: rdv = 32'h0;
      endcase
    end else begin
      case (rd_addr)
        vstt_pkg::ADDR_STATUS: begin
          for (int s = 0; s < NS; s++) begin
            rdv[s] = st_q[s];
            rdv[vstt_pkg::ST_TRIP_LSB + s] = tr_q[s];
            rdv[vstt_pkg::ST_BLK_LSB + s] = bl_q[s];
            rdv[vstt_pkg::ST_PTR_LSB + 4 * s +: 4] = wp[s];
          end
        end
        vstt_pkg::ADDR_EVMASK: rdv = {8'h00, evmask};
        vstt_pkg::ADDR_TIME: rdv = stamp;
        vstt_pkg::ADDR_RECSEL: rdv = {22'h0, recsel};
        vstt_pkg::ADDR_RECDATA: begin
          case (recsel[vstt_pkg::RECSEL_WORD_LSB +: 2])
            2'h0: rdv = rsel.stamp;
            2'h1: rdv = {rsel.pre_trigger, rsel.fault};
            2'h2: rdv = {rsel.pre_fault, 16'h0000};
            default: rdv = {rsel.remaining, 6'h00, rsel.group, rsel.event_code};
          endcase
        end
        default: rdv = 32'h0;
      endcase
    end
    next_wr_pend = take && hwrite_i;
    next_rd_pend = take && !hwrite_i;
    next_wr_addr = take ? haddr_i[7:0] : wr_addr;
    next_rd_addr = take ? haddr_i[7:0] : rd_addr;
    next_hreadyout = !(take && !hwrite_i);
    next_hrdata = rd_pend ? rdv : hrdata_o;
    next_cfg = cfg;
    next_evmask = evmask;
    next_recsel = recsel;
    if (wr_pend) begin
      if (wr_addr < vstt_pkg::STAGE_END) begin
        case (wr_addr[3:0])
          vstt_pkg::OFS_CFG: begin
            next_cfg[wr_addr[5:4]].delay_type = hwdata_i[vstt_pkg::CFG_TYPE_LSB +: 2];
            next_cfg[wr_addr[5:4]].delayed_release = hwdata_i[vstt_pkg::CFG_DELREL_LSB +: 2];
            next_cfg[wr_addr[5:4]].reset_after = hwdata_i[vstt_pkg::CFG_RSTAFT_LSB +: 2];
            next_cfg[wr_addr[5:4]].continue_release = hwdata_i[vstt_pkg::CFG_CONT_LSB +: 2];
            next_cfg[wr_addr[5:4]].under = hwdata_i[vstt_pkg::CFG_UNDER_BIT];
          end
          vstt_pkg::OFS_DELAY: next_cfg[wr_addr[5:4]].op_delay = hwdata_i[18:0];
          vstt_pkg::OFS_RELEASE: next_cfg[wr_addr[5:4]].release_delay = hwdata_i[14:0];
          vstt_pkg::OFS_INVERSE_TIME_MODE: begin
            next_cfg[wr_addr[5:4]].dial_k = hwdata_i[vstt_pkg::INVERSE_TIME_MODE_K_LSB +: 13];
            next_cfg[wr_addr[5:4]].exponent_a = hwdata_i[vstt_pkg::INVERSE_TIME_MODE_A_LSB +: 12];
          end
          default: next_recsel = recsel;
        endcase
      end else if (wr_addr == vstt_pkg::ADDR_EVMASK) begin
        next_evmask = hwdata_i[23:0];
      end else if (wr_addr == vstt_pkg::ADDR_RECSEL) begin
        next_recsel = hwdata_i[9:0];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      for (int s = 0; s < NS; s++) begin
        cfg[s] <= vstt_pkg::CFG_RESET;
      end
      evmask <= vstt_pkg::EVMASK_RESET;
      recsel <= 10'h000;
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      wr_addr <= 8'h00;
      rd_addr <= 8'h00;
      hreadyout_o <= 1'b1;
      hrdata_o <= 32'h0;
      hresp_o <= 1'b0;
      event_o <= 24'h000000;
      event_stamp_o <= 32'h0;
      event_voltage_o <= 16'h0;
    end else begin
      cfg <= next_cfg;
      evmask <= next_evmask;
      recsel <= next_recsel;
      wr_pend <= next_wr_pend;
      rd_pend <= next_rd_pend;
      wr_addr <= next_wr_addr;
      rd_addr <= next_rd_addr;
      hreadyout_o <= next_hreadyout;
      hrdata_o <= next_hrdata;
      hresp_o <= 1'b0;
      event_o <= next_event;
      event_stamp_o <= stamp;
      event_voltage_o <= measured_voltage_i;
    end
  end
endmodule // vstt_voltage_stage_trip_timer
